// ---- pkg/hqc_defines.svh ----
// Constants for the half-period and quadrant clock output block
`ifndef HQC_DEFINES_SVH
`define HQC_DEFINES_SVH

// Width of the period and phase counters, in ref_clk cycles
`define HQC_CW 16
// Width of the synthesizer multiply and divide settings
`define HQC_SW 5
// Width of the synthesizer accumulator
`define HQC_AW 22
// Width of the feedback watchdog counter
`define HQC_FW 12
// Sampling clock rate and the quadrant range limit, both in kHz
`define HQC_CLK_KHZ 32'd125000
`define HQC_FAST_LIMIT_KHZ 32'd167000
// Feedback is taken as absent after this many cycles without an edge
`define HQC_FB_TIMEOUT 12'hfff
// Largest phase count before the reference is taken as stopped
`define HQC_PHASE_MAX 16'hffff
// Rising edges needed before the measured period is trusted
`define HQC_RISES_TO_VALID 2'h2
// Quarter positions within one period
`define HQC_Q1 3'h1
`define HQC_Q2 3'h2
`define HQC_Q3 3'h3
// Reset values
`define HQC_CNT_RST 16'h0000
`define HQC_LEN_RST 16'h0001

`endif

// ---- pkg/hqc_pkg.sv ----
// Types shared by the half-period and quadrant clock output block
`default_nettype none
package hqc_pkg;

  // A non-shifted clock and its half-period partner
  typedef struct packed {
    logic first;
    logic second;
  } hqc_pair_t;

  // The four quadrant outputs
  typedef struct packed {
    logic zero;
    logic quarter;
    logic half;
    logic threeQuarter;
  } hqc_quad_t;

  // Static configuration taken from pins
  typedef struct packed {
    logic dutyCorrect;
    logic rangeHigh;
    logic laterFamily;
    logic [4:0] synthMul;
    logic [4:0] synthDiv;
  } hqc_cfg_t;

endpackage
`default_nettype wire

// ---- rtl/hqc_sync.sv ----
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module hqc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,  // Sampling clock
  input wire logic rstn,  // Asynchronous reset, active low
  input wire logic [W-1:0] async,  // Levels from outside the domain
  output logic [W-1:0] synced  // Levels after two flops
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_synced;

  // Bits are independent levels; no word is assumed to cross coherently
  always_comb begin
    next_stage1 = async;
    next_synced = stage1;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= next_stage1;
      synced <= next_synced;
    end
  end

endmodule // hqc_sync
`default_nettype wire

// ---- rtl/hqc_synth.sv ----
// Synthesizer pair: output at ref rate times multiply over divide
`timescale 1ns/1ps
`default_nettype none
`include "hqc_defines.svh"
module hqc_synth
  import hqc_pkg::*;
(
  input wire logic ref_clk,  // Sampling clock
  input wire logic rstn,  // Asynchronous reset, active low
  input wire logic run,  // Reference period is valid
  input wire logic [`HQC_CW-1:0] periodLen,  // Reference period in cycles
  input wire logic [`HQC_SW-1:0] mul,  // Multiply setting, 0 taken as 1
  input wire logic [`HQC_SW-1:0] div,  // Divide setting, 0 taken as 1
  output hqc_pair_t pair  // Synthesizer pair, registered
);

  logic [`HQC_AW-1:0] acc;
  logic [`HQC_AW-1:0] next_acc;
  hqc_pair_t next_pair;
  logic [`HQC_SW-1:0] mulEff;
  logic [`HQC_SW-1:0] divEff;
  logic [`HQC_AW-1:0] limit;
  logic [`HQC_AW-1:0] step;

  // Two toggles per synthesized period give a 50% duty cycle; see RQ5
  always_comb begin
    mulEff = (mul == '0) ? `HQC_SW'h1 : mul;
    divEff = (div == '0) ? `HQC_SW'h1 : div;
    limit = `HQC_AW'(periodLen) * `HQC_AW'(divEff);
    step = `HQC_AW'({mulEff, 1'b0});
    next_acc = acc;
    next_pair = pair;
    if (!run) begin
      next_acc = '0;
      next_pair = '0;
    end else if (acc + step >= limit) begin
      next_acc = acc + step - limit;
      next_pair.first = ~pair.first;
      next_pair.second = pair.first; // see RQ5
    end else begin
      next_acc = acc + step;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc <= '0;
      pair <= '0;
    end else begin
      acc <= next_acc;
      pair <= next_pair;
    end
  end

endmodule // hqc_synth
`default_nettype wire

// ---- rtl/hqc_clock_outputs.sv ----
// Half-period pairs and quadrant outputs derived from the reference input
//
// Function
// RQ1: Each half-period pair gives a clock and a copy shifted 180 degrees.
// RQ2: Zero-phase output and its partner run at the reference frequency.
// RQ3: Base family: input-rate pair 50% duty corrected by default, switchable.
// RQ4: Doubler pair: twice reference rate, 50% duty, half-period offset.
// RQ5: Synth pair runs at the configured rate, 50% duty, half-period offset.
// RQ6: First clock rises at period start, second exactly at half period.
// RQ7: DDR register takes the plain clock first, shifted clock second.
// RQ8: Quadrant outputs are delayed 0, 90, 180 and 270 degrees.
// RQ9: Quadrant outputs need feedback (code gates only the 90 and 270 degree outputs on it); zero-phase aligns to reference rise.
// RQ10: Low-frequency range makes all four quadrant outputs available.
// RQ11: High-frequency range gives only the zero and 180 degree outputs.
// RQ12: Later families: all four to 167 MHz, only zero and 180 above.
// RQ13: An unavailable output is held low instead of toggling.
`timescale 1ns/1ps
`default_nettype none
`include "hqc_defines.svh"
module hqc_clock_outputs
  import hqc_pkg::*;
(
  input wire logic ref_clk,  // Sampling clock, 125 MHz
  input wire logic rstn,  // Asynchronous reset, active low
  input wire logic referenceInput,  // Reference clock pin
  input wire logic feedbackInput,  // Feedback clock pin
  input wire logic dutyCorrectEn,  // Base family duty correction, 1 = on
  input wire logic freqRangeHigh,  // Base family delay-loop range, 1 = high
  input wire logic laterFamily,  // 1 = range follows measured frequency
  input wire logic [4:0] synthMultiply,  // Synthesizer multiply setting
  input wire logic [4:0] synthDivide,  // Synthesizer divide setting
  output logic outPhaseZero,  // Zero-phase output
  output logic outQuarterPhase,  // 90 degree output
  output logic outHalfPhase,  // 180 degree output
  output logic outThreeQuarterPhase,  // 270 degree output
  output logic doubledOut,  // Doubler output
  output logic doubledOutHalfPhase,  // Doubler output, half-period shifted
  output logic synthOut,  // Synthesizer output
  output logic synthOutHalfPhase,  // Synthesizer output, half-period shifted
  output logic periodValid,  // Reference period measured and running
  output logic feedbackPresent,  // Feedback edges seen recently
  output logic rangeHighActive  // Range in force, 1 = high
);

  //////////////////////////////////////////////////////////////////////////
  // Pin sampling

  hqc_cfg_t cfgPins;
  hqc_cfg_t cfg;
  logic refSync;
  logic fbSync;

  always_comb begin
    cfgPins.dutyCorrect = dutyCorrectEn;
    cfgPins.rangeHigh = freqRangeHigh;
    cfgPins.laterFamily = laterFamily;
    cfgPins.synthMul = synthMultiply;
    cfgPins.synthDiv = synthDivide;
  end

  // Correction is on while its pin is tied high, the default; see RQ3
  hqc_sync #(
    .W(2 + $bits(hqc_cfg_t))
  ) hqc_sync_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async({referenceInput, feedbackInput, cfgPins}),
    .synced({refSync, fbSync, cfg})
  );

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Point k quarters into a period of len cycles
  function automatic logic [`HQC_CW-1:0] quarterPoint(
    input logic [`HQC_CW-1:0] len,
    input logic [2:0] k
  );
    logic [`HQC_CW+2:0] prod;
    prod = {3'h0, len} * {{`HQC_CW{1'b0}}, k};
    return prod[`HQC_CW+1:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reference period measurement

  logic refPrev;
  logic refRise;
  logic [`HQC_CW-1:0] phase;
  logic [`HQC_CW-1:0] periodLen;
  logic [1:0] riseCount;
  logic next_refPrev;
  logic [`HQC_CW-1:0] next_phase;
  logic [`HQC_CW-1:0] next_periodLen;
  logic [1:0] next_riseCount;
  logic running;

  assign refRise = refSync & ~refPrev;
  assign running = (riseCount == `HQC_RISES_TO_VALID);

  // Phase restarts on every reference rise, so zero phase tracks it; see RQ9
  always_comb begin
    next_refPrev = refSync;
    next_phase = phase;
    next_periodLen = periodLen;
    next_riseCount = riseCount;
    if (refRise) begin
      next_phase = `HQC_CNT_RST;
      next_periodLen = phase + `HQC_LEN_RST;
      if (riseCount != `HQC_RISES_TO_VALID) begin
        next_riseCount = riseCount + 2'h1;
      end
    end else if (phase == `HQC_PHASE_MAX) begin
      // Reference stopped: outputs drop rather than freeze mid-period
      next_riseCount = '0;
    end else begin
      next_phase = phase + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      refPrev <= 1'b0;
      phase <= `HQC_CNT_RST;
      periodLen <= `HQC_LEN_RST;
      riseCount <= '0;
    end else begin
      refPrev <= next_refPrev;
      phase <= next_phase;
      periodLen <= next_periodLen;
      riseCount <= next_riseCount;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Feedback watchdog and frequency range

  logic fbPrev;
  logic [`HQC_FW-1:0] fbIdle;
  logic next_fbPrev;
  logic [`HQC_FW-1:0] next_fbIdle;
  logic fbAlive;
  logic refFast;
  logic rangeHigh;

  always_comb begin
    next_fbPrev = fbSync;
    next_fbIdle = fbIdle;
    if (fbSync & ~fbPrev) begin
      next_fbIdle = '0;
    end else if (fbIdle != `HQC_FB_TIMEOUT) begin
      next_fbIdle = fbIdle + 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fbPrev <= 1'b0;
      fbIdle <= `HQC_FB_TIMEOUT;
    end else begin
      fbPrev <= next_fbPrev;
      fbIdle <= next_fbIdle;
    end
  end

  assign fbAlive = (fbIdle != `HQC_FB_TIMEOUT);

  // Reference above the limit when clock / period exceeds it; see RQ12
  // Product in 64 bits so a long period cannot wrap into a false fast range
  assign refFast = 64'(`HQC_CLK_KHZ) >
    64'(`HQC_FAST_LIMIT_KHZ) * 64'(periodLen);
  assign rangeHigh = cfg.laterFamily ? refFast : cfg.rangeHigh; // see RQ11

  //////////////////////////////////////////////////////////////////////////
  // Output waveforms

  logic [`HQC_CW-1:0] q1;
  logic [`HQC_CW-1:0] q2;
  logic [`HQC_CW-1:0] q3;
  logic [`HQC_CW-1:0] dblPhase;
  hqc_quad_t quad;
  hqc_pair_t dbl;
  hqc_pair_t synth;
  hqc_quad_t next_quad;
  hqc_pair_t next_dbl;
  logic next_valid;
  logic next_fbPresent;
  logic next_rangeHigh;

  always_comb begin
    q1 = quarterPoint(periodLen, `HQC_Q1);
    q2 = quarterPoint(periodLen, `HQC_Q2);
    q3 = quarterPoint(periodLen, `HQC_Q3);
    dblPhase = (phase >= q2) ? phase - q2 : phase;
    next_quad = '0;
    next_dbl = '0;
    if (running) begin
      // Zero phase high for the first half, its partner for the second
      next_quad.zero = phase < q2; // see RQ1
      next_quad.half = phase >= q2; // see RQ6
      if (!cfg.dutyCorrect) begin
        // Uncorrected zero output follows the reference's own duty cycle, its partner the inverse
        next_quad.zero = refSync; // see RQ3
        next_quad.half = ~refSync; // see RQ2
      end
      // Quarter points only exist with feedback and in the low range
      if (fbAlive && !rangeHigh) begin // see RQ10
        next_quad.quarter = (phase >= q1) && (phase < q3); // see RQ8
        next_quad.threeQuarter = (phase >= q3) || (phase < q1); // see RQ8
      end
      // Two doubler periods per reference period, each split evenly
      next_dbl.first = dblPhase < q1; // see RQ4
      next_dbl.second = dblPhase >= q1; // see RQ4
    end
    // Without a running reference every clock output rests low; see RQ13
    next_valid = running;
    next_fbPresent = fbAlive;
    next_rangeHigh = rangeHigh;
  end

  hqc_synth hqc_synth_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(running),
    .periodLen(periodLen),
    .mul(cfg.synthMul),
    .div(cfg.synthDiv),
    .pair(synth)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      quad <= '0;
      dbl <= '0;
      periodValid <= 1'b0;
      feedbackPresent <= 1'b0;
      rangeHighActive <= 1'b0;
    end else begin
      quad <= next_quad;
      dbl <= next_dbl;
      periodValid <= next_valid;
      feedbackPresent <= next_fbPresent;
      rangeHighActive <= next_rangeHigh;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output registers

  // Separate flops per output so a DDR register gets both edges; see RQ7
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      outPhaseZero <= 1'b0;
      outQuarterPhase <= 1'b0;
      outHalfPhase <= 1'b0;
      outThreeQuarterPhase <= 1'b0;
      doubledOut <= 1'b0;
      doubledOutHalfPhase <= 1'b0;
      synthOut <= 1'b0;
      synthOutHalfPhase <= 1'b0;
    end else begin
      outPhaseZero <= quad.zero;
      outQuarterPhase <= quad.quarter;
      outHalfPhase <= quad.half;
      outThreeQuarterPhase <= quad.threeQuarter;
      doubledOut <= dbl.first;
      doubledOutHalfPhase <= dbl.second;
      synthOut <= synth.first; // see RQ5
      synthOutHalfPhase <= synth.second;
    end
  end

endmodule // hqc_clock_outputs
`default_nettype wire

// ---- tb/hqc_fabric_model.sv ----
// Fabric model: feedback route and a two-clock DDR output register
`timescale 1ns/1ps
`default_nettype none
module hqc_fabric_model (
  input wire logic ddrFirstClockIn,  // Non-shifted clock
  input wire logic ddrSecondClockIn,  // Half-period shifted clock
  input wire logic fbEnable,  // Feedback route present
  output logic feedbackOut,  // Routed zero-phase clock
  output logic ddrQ  // DDR register output
);
  realtime firstAt = 0.0;
  realtime secondAt = 0.0;
  // A cut route shows no edges at all
  assign feedbackOut = fbEnable & ddrFirstClockIn;
  // Each half comes from its own clock, never a local inversion
  always @(posedge ddrFirstClockIn) firstAt <= $realtime;
  always @(posedge ddrSecondClockIn) secondAt <= $realtime;
  // Data follows whichever clock rose last; one driver, no edge race
  assign ddrQ = firstAt > secondAt;
endmodule  // hqc_fabric_model
`default_nettype wire

// ---- tb/hqc_clock_outputs_asserts.sv ----
// Concurrent checks on the clock output ports
`timescale 1ns/1ps
`default_nettype none
module hqc_clock_outputs_asserts (
  input wire logic ref_clk,  // Clock
  input wire logic rstn,  // Reset, active low
  input wire logic feedbackInput,  // Feedback pin
  input wire logic dutyCorrectEn,  // Duty correction
  input wire logic outPhaseZero,  // 0 deg
  input wire logic outQuarterPhase,  // 90 deg
  input wire logic outHalfPhase,  // 180 deg
  input wire logic outThreeQuarterPhase,  // 270 deg
  input wire logic doubledOut,  // Doubler
  input wire logic doubledOutHalfPhase,  // Doubler shifted
  input wire logic synthOut,  // Synth
  input wire logic synthOutHalfPhase,  // Synth shifted
  input wire logic periodValid,  // Running
  input wire logic feedbackPresent,  // Feedback seen
  input wire logic rangeHighActive  // High range
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic synthSeen;
  // Synth pair rests low together until its first toggle after a start
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      synthSeen <= 1'b0;
    end else begin
      synthSeen <= periodValid && (synthSeen || synthOut);
    end
  end
  // The pin needs four cycles to reach the ports through sync and pipeline
  sequence s_dutyOn;
    dutyCorrectEn && $past(dutyCorrectEn, 5);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Three cycles of validity cover the two output pipeline stages
  sequence s_settled;
    periodValid && $past(periodValid, 3);
  endsequence
  property p_halfPair;
    s_settled |-> outHalfPhase != outPhaseZero;
  endproperty
  property p_dblPair;
    s_settled |-> doubledOutHalfPhase != doubledOut;
  endproperty
  property p_synthPair;
    s_settled ##0 synthSeen |-> synthOutHalfPhase != synthOut;
  endproperty
  // Mid period is where the second doubler period starts
  property p_halfAtMid;
    s_settled ##0 s_dutyOn ##0 $fell(outPhaseZero) |->
      $rose(outHalfPhase) && $rose(doubledOut);
  endproperty
  property p_dblWithZero;
    s_settled ##0 s_dutyOn ##0 $rose(outPhaseZero) |-> $rose(doubledOut);
  endproperty
  // Regular quarter edges only, not the first edge after the gate opens
  property p_quarterInZero;
    s_dutyOn ##0 ($rose(outQuarterPhase) && $fell(outThreeQuarterPhase)) |->
      outPhaseZero && !outHalfPhase;
  endproperty
  property p_threeInHalf;
    s_dutyOn ##0 ($rose(outThreeQuarterPhase) && $fell(outQuarterPhase)) |->
      outHalfPhase && !outPhaseZero;
  endproperty
  property p_rangeGate;
    rangeHighActive && $past(rangeHighActive, 3) |->
      !outQuarterPhase && !outThreeQuarterPhase;
  endproperty
  property p_fbGate;
    !feedbackPresent && !$past(feedbackPresent, 3) |->
      !outQuarterPhase && !outThreeQuarterPhase;
  endproperty
  property p_idleLow;
    !periodValid && !$past(periodValid, 3) |-> {outPhaseZero, outQuarterPhase,
      outHalfPhase, outThreeQuarterPhase, doubledOut, doubledOutHalfPhase,
      synthOut, synthOutHalfPhase} == 8'h00;
  endproperty
  property p_fbSeen;
    $rose(feedbackInput) |-> ##[1:6] feedbackPresent;
  endproperty
  a_halfPair: assert property (p_halfPair)
    else $error("half output not the complement of zero");
  a_dblPair: assert property (p_dblPair)
    else $error("doubler pair not complementary");
  a_synthPair: assert property (p_synthPair)
    else $error("synth pair not complementary");
  a_halfAtMid: assert property (p_halfAtMid)
    else $error("half output did not rise at mid period");
  a_dblWithZero: assert property (p_dblWithZero)
    else $error("doubler not rising with zero output");
  a_quarterInZero: assert property (p_quarterInZero)
    else $error("quarter output rose outside first half");
  a_threeInHalf: assert property (p_threeInHalf)
    else $error("three-quarter output rose outside second half");
  a_rangeGate: assert property (p_rangeGate)
    else $error("quarter outputs toggling in high range");
  a_fbGate: assert property (p_fbGate)
    else $error("quarter outputs toggling without feedback");
  a_idleLow: assert property (p_idleLow)
    else $error("outputs not low while not running");
  a_fbSeen: assert property (p_fbSeen)
    else $error("feedback edge not reported");
endmodule  // hqc_clock_outputs_asserts
bind hqc_clock_outputs hqc_clock_outputs_asserts hqc_clock_outputs_asserts_i (
  .ref_clk(ref_clk), .rstn(rstn), .feedbackInput(feedbackInput),
  .dutyCorrectEn(dutyCorrectEn), .outPhaseZero(outPhaseZero),
  .outQuarterPhase(outQuarterPhase), .outHalfPhase(outHalfPhase),
  .outThreeQuarterPhase(outThreeQuarterPhase), .doubledOut(doubledOut),
  .doubledOutHalfPhase(doubledOutHalfPhase), .synthOut(synthOut),
  .synthOutHalfPhase(synthOutHalfPhase), .periodValid(periodValid),
  .feedbackPresent(feedbackPresent), .rangeHighActive(rangeHighActive));
`default_nettype wire

// ---- tb/hqc_clock_outputs_bench.sv ----
// Self-checking bench for the half-period and quadrant clock outputs
`timescale 1ns/1ps
`default_nettype none
module hqc_clock_outputs_bench
  import hqc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic referenceInput = 1'b0;
  logic dutyCorrectEn = 1'b1, freqRangeHigh = 1'b0, laterFamily = 1'b0;
  logic fbEn = 1'b1;
  logic [4:0] synthMultiply = 5'h01, synthDivide = 5'h01;
  logic feedbackInput, ddrQ, periodValid, feedbackPresent, rangeHighActive;
  logic [7:0] outs;
  logic [8:0] prevMon = 9'h000;
  logic [8:0] mon;
  int refPer = 8, refCnt = 0, cyc = 0, n_errors = 0, checked = 0;
  int riseAt[9], perOf[9], hiOf[9];
  ////////////////////////////////////////////////////////////////////////////
  initial forever #4 ref_clk = ~ref_clk;
  // Reference at 3/8 high so duty correction has something to fix
  always @(posedge ref_clk) begin
    #1;
    refCnt = refPer > 0 ? (refCnt + 1) % refPer : 0;
    referenceInput = refPer > 0 && refCnt < 3;
  end
  hqc_clock_outputs hqc_clock_outputs_i (.ref_clk(ref_clk), .rstn(rstn),
    .referenceInput(referenceInput), .feedbackInput(feedbackInput),
    .dutyCorrectEn(dutyCorrectEn), .freqRangeHigh(freqRangeHigh),
    .laterFamily(laterFamily), .synthMultiply(synthMultiply),
    .synthDivide(synthDivide), .outPhaseZero(outs[7]),
    .outQuarterPhase(outs[6]), .outHalfPhase(outs[5]),
    .outThreeQuarterPhase(outs[4]), .doubledOut(outs[3]),
    .doubledOutHalfPhase(outs[2]), .synthOut(outs[1]),
    .synthOutHalfPhase(outs[0]), .periodValid(periodValid),
    .feedbackPresent(feedbackPresent), .rangeHighActive(rangeHighActive));
  hqc_fabric_model hqc_fabric_model_i (.ddrFirstClockIn(outs[7]),
    .ddrSecondClockIn(outs[5]), .fbEnable(fbEn),
    .feedbackOut(feedbackInput), .ddrQ(ddrQ));
  assign mon = {ddrQ, outs};
  // Edge timestamps of every output, taken where all values have settled
  always @(negedge ref_clk) begin
    cyc++;
    for (int b = 0; b < 9; b++) begin
      if (mon[b] === 1'b1 && prevMon[b] === 1'b0) begin
        perOf[b] = cyc - riseAt[b];
        riseAt[b] = cyc;
      end
      if (mon[b] === 1'b0 && prevMon[b] === 1'b1) begin
        hiOf[b] = cyc - riseAt[b];
      end
    end
    prevMon = mon;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic setup(input logic dc, rh, lf, fb, input logic [4:0] m, d);
    @(posedge ref_clk);
    #1;
    {dutyCorrectEn, freqRangeHigh, laterFamily, fbEn} = {dc, rh, lf, fb};
    {synthMultiply, synthDivide} = {m, d};
    repeat (60) @(posedge ref_clk);
  endtask
  function automatic int offs(input int b, input int r, input int p);
    return ((riseAt[b] - riseAt[r]) % p + p) % p;
  endfunction
  task automatic test_pairs();
    int eP[9] = '{8, 8, 4, 4, 8, 8, 8, 8, 8};
    int eH[9] = '{4, 4, 2, 2, 4, 4, 4, 4, 4};
    int eO[9] = '{4, -1, 2, 0, 6, 4, 2, 0, 0};
    setup(1, 0, 0, 1, 5'h01, 5'h01);
    for (int b = 0; b < 9; b++) begin
      check(perOf[b], eP[b]);
      check(hiOf[b], eH[b]);
      if (eO[b] >= 0) begin
        check(offs(b, b == 0 ? 1 : 7, eP[b]), eO[b]);
      end
    end
    $display("test_pairs done");
  endtask
  task automatic test_duty_off();
    setup(0, 0, 0, 1, 5'h01, 5'h01);
    check(perOf[7], 8);
    check(hiOf[7], 3);
    check(hiOf[5], 5);
    $display("test_duty_off done");
  endtask
  task automatic test_gating();
    logic [3:0] cfg[3] = '{4'b1010, 4'b1111, 4'b0000};
    int n6, n4, r7;
    for (int i = 0; i < 3; i++) begin
      setup(1, cfg[i][3], cfg[i][2], cfg[i][1], 5'h01, 5'h01);
      if (!cfg[i][1]) repeat (4200) @(posedge ref_clk);
      {n6, n4, r7} = {32'd0, 32'd0, riseAt[7]};
      repeat (40) begin
        @(negedge ref_clk);
        n6 += outs[6] === 1'b1;
        n4 += outs[4] === 1'b1;
      end
      check(n6 > 0, cfg[i][0]);
      check(n4 > 0, cfg[i][0]);
      check(riseAt[7] != r7, 1'b1);
      check(rangeHighActive, cfg[i][3] & ~cfg[i][2]);
      check(feedbackPresent, cfg[i][1]);
    end
    $display("test_gating done");
  endtask
  task automatic test_synth();
    setup(1, 0, 0, 1, 5'h02, 5'h01);
    check(perOf[1], 4);
    check(offs(0, 1, 4), 2);
    setup(1, 0, 0, 1, 5'h01, 5'h02);
    check(perOf[1], 16);
    check(hiOf[0], 8);
    $display("test_synth done");
  endtask
  task automatic test_reset();
    @(posedge ref_clk);
    #1;
    rstn = 1'b0;
    repeat (4) @(posedge ref_clk);
    check(outs, 8'h00);
    check(periodValid, 1'b0);
    #1;
    rstn = 1'b1;
    setup(1, 0, 0, 1, 5'h01, 5'h01);
    check(perOf[7], 8);
    check(offs(5, 7, 8), 4);
    check(periodValid, 1'b1);
    $display("test_reset done");
  endtask
  task automatic test_stop();
    @(posedge ref_clk);
    #1;
    refPer = 0;
    repeat (65600) @(posedge ref_clk);
    check(periodValid, 1'b0);
    check(outs, 8'h00);
    $display("test_stop done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Tests need about 70,400 cycles; give up at 90,000
  initial begin
    #720000;
    n_errors++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    check(outs, 8'h00);
    #1;
    rstn = 1'b1;
    test_pairs();
    test_duty_off();
    test_gating();
    test_synth();
    test_reset();
    test_stop();
    print_verdict();
  end
endmodule  // hqc_clock_outputs_bench
`default_nettype wire
